// File: common/half_bridge_params.svh
// Purpose: Constants for the half-bridge output control block
// Assumes: Core clock of 10 MHz, 24-bit serial frames
// Notes:   Timing counts derive from times in microseconds
`ifndef HALF_BRIDGE_PARAMS_SVH
`define HALF_BRIDGE_PARAMS_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define FRAME_BITS        24
`define CMD_LSB           1
`define CMD_MSB           10
`define DUTY_BIT          21
`define NO_ERROR_BIT      0
`define CMD_RESET         10'h000
`define FLAG_RESET        10'h000
`define WORD_RESET        24'h000000

// ----------------------------------------------------------------
// Test-mode select patterns on bits 10..5 (upper/lower of bridges 5..3)
// ----------------------------------------------------------------
`define TSEL_IREF         6'h00
`define TSEL_TEMP_A       6'h03
`define TSEL_TEMP_B       6'h0c
`define TSEL_TEMP_C       6'h0f
`define TSEL_TEMP_D       6'h30
`define TSEL_BANDGAP      6'h3f

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ           10
`define REC_OFF_SHORT_US  40
`define REC_OFF_LONG_US   80
`define REC_OFF_SHORT_CYC (`REC_OFF_SHORT_US * `CLK_MHZ)
`define REC_OFF_LONG_CYC  (`REC_OFF_LONG_US * `CLK_MHZ)

`endif

// File: common/half_bridge_pkg.sv
// Purpose: Types shared by the half-bridge output control block
// Assumes: Nothing beyond the params header
// Notes:   Constants live in half_bridge_params.svh
package half_bridge_pkg;

  typedef logic [23:0] frame_word_t;

  typedef enum logic [2:0] {
    MUX_IREF,
    MUX_TEMP_A,
    MUX_TEMP_B,
    MUX_TEMP_C,
    MUX_TEMP_D,
    MUX_BANDGAP,
    MUX_NONE
  } analog_mux_t;

endpackage

// File: common/frame_link_if.sv
// Purpose: Carries frames between the serial front end and the core
// Assumes: rx_word is stable whenever rx_toggle is unchanged
// Notes:   tx_word is held still by the core while a frame runs
`timescale 1ns/1ns
interface frame_link_if;
  import half_bridge_pkg::*;

  frame_word_t rx_word;
  logic        rx_toggle;
  frame_word_t tx_word;

  modport link (
    output rx_word,
    output rx_toggle,
    input  tx_word
  );

  modport core (
    input  rx_word,
    input  rx_toggle,
    output tx_word
  );
endinterface

// File: hw/serial_link_port.sv
// Purpose: Serial front end on the link clock: shifts in, shifts out
// Assumes: Mode with sampling on rising, launch on falling link edge
// Notes:   Chip select high clears the frame state asynchronously
`timescale 1ns/1ns
`include "half_bridge_params.svh"
module serial_link_port (
  // Link pins
  input  wire logic  link_sclk_i,
  input  wire logic  chip_select_low_i,
  input  wire logic  serial_in_i,
  output logic       serial_out_o,
  output logic       serial_out_oe_o,
  // Core reset
  input  wire logic  reset_n_i,
  // Frame carrier
  frame_link_if.link frame
);
  import half_bridge_pkg::*;

  logic [4:0]  bit_cnt;
  logic [22:0] shift;
  logic [4:0]  tx_index;
  wire         last_bit = (bit_cnt == 5'(`FRAME_BITS - 1));
  wire         in_frame = (bit_cnt < 5'(`FRAME_BITS));

  assign tx_index = 5'(`FRAME_BITS - 1) - bit_cnt;

  // ----------------------------------------------------------------
  // Receive
  // ----------------------------------------------------------------
  always_ff @(posedge link_sclk_i or posedge chip_select_low_i) begin
    if (chip_select_low_i) begin
      bit_cnt <= 5'h00;
      shift   <= 23'h000000;
    end else if (in_frame) begin
      bit_cnt <= bit_cnt + 5'h01;
      shift   <= {shift[21:0], serial_in_i};
    end
  end

  // Only a full frame is handed over; short frames leave no trace
  always_ff @(posedge link_sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame.rx_word   <= `WORD_RESET;
      frame.rx_toggle <= 1'b0;
    end else if (last_bit) begin
      frame.rx_word   <= {shift, serial_in_i};
      frame.rx_toggle <= ~frame.rx_toggle;
    end
  end

  // ----------------------------------------------------------------
  // Transmit
  // ----------------------------------------------------------------
  // Top bit of the status word is zero, so it needs no preload
  always_ff @(negedge link_sclk_i or posedge chip_select_low_i) begin
    if (chip_select_low_i) begin
      serial_out_o    <= 1'b0;
      serial_out_oe_o <= 1'b0;
    end else begin
      serial_out_o    <= in_frame ? frame.tx_word[tx_index] : 1'b0;
      serial_out_oe_o <= 1'b1;
    end
  end
endmodule

// File: hw/half_bridge_output_control.sv
// Purpose: Command and status word for five half bridges
// Assumes: Chip select low at least three core clocks before first edge
// Notes:   Enable, PWM and recovery settings arrive as core-clock inputs
//
// Overview of operation
// - Write bits 10..1 command bridges five..one; same read bits flag trips
// - With PWM enable set, a switch conducts only while its gate is high
// - Both switches of one bridge are never on together
// - Test mode routes an internal signal chosen by bridge 3..5 bits
// - Over-current sets the switch's flag and turns that driver off
// - With recovery enabled the driver retries; bit 21 sets the delay
// - Read bit 0 is the NOR of all status flags
// - Written bits 13..11 and 0 ignored; read bits 13 and 12 are zero
// - Clearing the enable bit gives standby and clears the command bits, the bit 21 delay and the trip flags
`timescale 1ns/1ns
`include "half_bridge_params.svh"
module half_bridge_output_control (
  // Core clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  // Serial link
  input  wire logic                       link_sclk_i,
  input  wire logic                       chip_select_low_i,
  input  wire logic                       serial_in_i,
  output logic                            serial_out_o,
  output logic                            serial_out_oe_o,
  // Control bits held elsewhere in the device
  input  wire logic                       device_enable_i,
  input  wire logic                       oc_clear_i,
  input  wire logic [4:0]                 pwm_enable_i,
  input  wire logic [4:0]                 pwm_select_b_i,
  input  wire logic [9:0]                 recovery_enable_i,
  input  wire logic                       other_flags_i,
  // Pins from the analog side
  input  wire logic                       pwm_gate_input_a_i,
  input  wire logic                       pwm_gate_input_b_i,
  input  wire logic                       test_mode_i,
  input  wire logic [9:0]                 oc_sense_i,
  // Drivers and analog mux
  output logic [4:0]                      upper_switch_o,
  output logic [4:0]                      lower_switch_o,
  output logic [9:0]                      oc_flags_o,
  output half_bridge_pkg::analog_mux_t    analog_mux_select_o
);
  import half_bridge_pkg::*;

  localparam int SYNC_W = 15;

  // ----------------------------------------------------------------
  // Serial front end
  // ----------------------------------------------------------------
  frame_link_if frame ();

  serial_link_port link_port (
    .link_sclk_i       (link_sclk_i),
    .chip_select_low_i (chip_select_low_i),
    .serial_in_i       (serial_in_i),
    .serial_out_o      (serial_out_o),
    .serial_out_oe_o   (serial_out_oe_o),
    .reset_n_i         (reset_n_i),
    .frame             (frame.link)
  );

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_out;
  wire  [SYNC_W-1:0] async_in = {chip_select_low_i, frame.rx_toggle,
                                 test_mode_i, pwm_gate_input_b_i,
                                 pwm_gate_input_a_i, oc_sense_i};

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sync_meta <= '0;
      sync_out  <= '0;
    end else begin
      sync_meta <= async_in;
      sync_out  <= sync_meta;
    end
  end

  wire       cs_idle    = sync_out[14];
  wire       rx_tog_s   = sync_out[13];
  wire       test_mode  = sync_out[12];
  wire       gate_b     = sync_out[11];
  wire       gate_a     = sync_out[10];
  wire [9:0] oc_sense   = sync_out[9:0];

  // ----------------------------------------------------------------
  // Command word
  // ----------------------------------------------------------------
  logic       rx_tog_seen;
  logic [9:0] cmd;
  logic       duty_short;
  logic [9:0] next_cmd;
  logic       next_duty_short;
  logic       standby;
  wire        new_frame = (rx_tog_s != rx_tog_seen);

  assign standby = ~device_enable_i;

  // Bits 23..22, 20..11 and 0 of the word are not used here
  wire [9:0] rx_cmd = frame.rx_word[`CMD_MSB:`CMD_LSB];

  assign next_cmd = standby   ? `CMD_RESET :
                    new_frame ? rx_cmd :
                    cmd;
  assign next_duty_short = standby ? 1'b0 :
                           new_frame ? frame.rx_word[`DUTY_BIT] :
                           duty_short;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rx_tog_seen <= 1'b0;
      cmd         <= `CMD_RESET;
      duty_short  <= 1'b0;
    end else begin
      rx_tog_seen <= rx_tog_s;
      cmd         <= next_cmd;
      duty_short  <= next_duty_short;
    end
  end

  // ----------------------------------------------------------------
  // Per-switch protection
  // ----------------------------------------------------------------
  // Index 2k is the lower switch of bridge k, 2k+1 the upper switch
  logic [9:0] oc_flag;
  logic [9:0] blanked;
  logic [9:0] want_on;
  wire  [9:0] rec_load = duty_short ? 10'(`REC_OFF_SHORT_CYC)
                                    : 10'(`REC_OFF_LONG_CYC);

  genvar g;
  generate
    for (g = 0; g < 10; g++) begin : g_switch
      logic [9:0] rec_cnt;
      wire        pwm_on  = pwm_select_b_i[g/2] ? gate_b : gate_a;
      wire        gated   = ~pwm_enable_i[g/2] | pwm_on;
      wire        trip    = oc_sense[g] & ~blanked[g];
      wire        rec_end = recovery_enable_i[g] &
                            (rec_cnt == 10'h001);
      wire        release_off = oc_clear_i | rec_end;

      assign want_on[g] = cmd[g] & gated & ~blanked[g] & ~test_mode;

      always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
          oc_flag[g] <= 1'b0;
          blanked[g] <= 1'b0;
          rec_cnt    <= 10'h000;
        end else if (standby) begin
          oc_flag[g] <= 1'b0;
          blanked[g] <= 1'b0;
          rec_cnt    <= 10'h000;
        end else if (trip) begin
          // A trip in the clear cycle wins over the clear
          oc_flag[g] <= 1'b1;
          blanked[g] <= 1'b1;
          rec_cnt    <= rec_load;
        end else begin
          if (oc_clear_i) begin
            oc_flag[g] <= 1'b0;
          end
          if (blanked[g] && release_off) begin
            blanked[g] <= 1'b0;
            rec_cnt    <= 10'h000;
          end else if (rec_cnt != 10'h000) begin
            rec_cnt <= rec_cnt - 10'h001;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bridge drive with interlock
  // ----------------------------------------------------------------
  logic [4:0] next_upper;
  logic [4:0] next_lower;

  generate
    for (g = 0; g < 5; g++) begin : g_bridge
      // Both commands set: bridge floats rather than pick a winner
      wire both = cmd[2*g] & cmd[2*g+1];
      assign next_upper[g] = want_on[2*g+1] & ~both;
      assign next_lower[g] = want_on[2*g] & ~both;
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      upper_switch_o <= 5'h00;
      lower_switch_o <= 5'h00;
    end else begin
      upper_switch_o <= next_upper;
      lower_switch_o <= next_lower;
    end
  end

  // ----------------------------------------------------------------
  // Test-mode analog mux
  // ----------------------------------------------------------------
  wire [5:0]   tsel = cmd[9:4];
  analog_mux_t next_mux;

  assign next_mux = !test_mode               ? MUX_NONE    :
                    (tsel == `TSEL_IREF)     ? MUX_IREF    :
                    (tsel == `TSEL_TEMP_A)   ? MUX_TEMP_A  :
                    (tsel == `TSEL_TEMP_B)   ? MUX_TEMP_B  :
                    (tsel == `TSEL_TEMP_C)   ? MUX_TEMP_C  :
                    (tsel == `TSEL_TEMP_D)   ? MUX_TEMP_D  :
                    (tsel == `TSEL_BANDGAP)  ? MUX_BANDGAP :
                    MUX_NONE;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      analog_mux_select_o <= MUX_NONE;
      oc_flags_o          <= `FLAG_RESET;
    end else begin
      analog_mux_select_o <= next_mux;
      oc_flags_o          <= oc_flag;
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  // Refreshed only between frames so the link side shifts a still word
  frame_word_t status_word;
  frame_word_t next_status;
  wire         no_error = ~(|oc_flag | other_flags_i);

  assign next_status = {13'h0000, oc_flag, no_error};

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      status_word <= `WORD_RESET;
    end else if (cs_idle) begin
      status_word <= next_status;
    end
  end

  assign frame.tx_word = status_word;
endmodule

// File: testbench/half_bridge_checker.sv
// Purpose: Port-level properties of the half-bridge control block
// Assumes: Four-cycle windows cover the two-stage input synchronisers
// Notes:   Bound to every instance of the block
`timescale 1ns/1ns
module half_bridge_checker (
  // Core clock and reset
  input wire logic                     clk_i,
  input wire logic                     reset_n_i,
  // Control and pins
  input wire logic                     device_enable_i,
  input wire logic                     oc_clear_i,
  input wire logic [4:0]               pwm_enable_i,
  input wire logic [4:0]               pwm_select_b_i,
  input wire logic                     pwm_gate_input_a_i,
  input wire logic                     pwm_gate_input_b_i,
  input wire logic                     test_mode_i,
  // Outputs watched
  input wire logic [4:0]               upper_switch_o,
  input wire logic [4:0]               lower_switch_o,
  input wire logic [9:0]               oc_flags_o,
  input wire half_bridge_pkg::analog_mux_t analog_mux_select_o
);
  import half_bridge_pkg::*;
  wire [4:0] gate_v = (pwm_select_b_i & {5{pwm_gate_input_b_i}})
                    | (~pwm_select_b_i & {5{pwm_gate_input_a_i}});
  wire       gated  = (pwm_enable_i & ~gate_v) == 5'h1f;
  wire [4:0] on_v   = upper_switch_o | lower_switch_o;

  AST_NO_CROSS: assert property (@(posedge clk_i)
    disable iff (!reset_n_i) (upper_switch_o & lower_switch_o) == 5'h00)
    else $error("both switches of one bridge on");
  AST_PWM_GATE: assert property (@(posedge clk_i)
    disable iff (!reset_n_i) gated [*4] |-> on_v == 5'h00)
    else $error("switch on while its gate is low");
  AST_TEST_OFF: assert property (@(posedge clk_i)
    disable iff (!reset_n_i) test_mode_i [*4] |-> on_v == 5'h00)
    else $error("switch on in test mode");
  AST_MUX_IDLE: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    !test_mode_i [*4] |-> analog_mux_select_o == MUX_NONE)
    else $error("mux selected outside test mode");
  AST_TRIP_OFF: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    $rose(oc_flags_o[0]) |-> ##[0:2] !lower_switch_o[0])
    else $error("tripped driver still on");
  AST_STICKY: assert property (@(posedge clk_i)
    disable iff (!reset_n_i) (!oc_clear_i && device_enable_i) [*4]
    |-> (oc_flags_o & $past(oc_flags_o)) == $past(oc_flags_o))
    else $error("flag dropped without clear");
  AST_STANDBY: assert property (@(posedge clk_i)
    disable iff (!reset_n_i) !device_enable_i [*4]
    |-> on_v == 5'h00 && oc_flags_o == 10'h000)
    else $error("standby left outputs or flags set");
  AST_RESET_STATE: assert property (@(posedge clk_i)
    disable iff (!reset_n_i) $rose(reset_n_i)
    |-> on_v == 5'h00 && oc_flags_o == 10'h000)
    else $error("state not cleared by reset");
endmodule
bind half_bridge_output_control half_bridge_checker half_bridge_checker_inst (
  .clk_i, .reset_n_i, .device_enable_i, .oc_clear_i, .pwm_enable_i,
  .pwm_select_b_i, .pwm_gate_input_a_i, .pwm_gate_input_b_i, .test_mode_i,
  .upper_switch_o, .lower_switch_o, .oc_flags_o, .analog_mux_select_o);

// File: testbench/link_master_model.sv
// Purpose: Serial master that sends 24-bit words and captures replies
// Assumes: Link clock of 12 ns, idle low, runs only inside frames
// Notes:   Bit 23 of the reply is never driven and is taken as zero
`timescale 1ns/1ns
module link_master_model (
  // Link pins
  output logic      link_sclk_o,
  output logic      chip_select_low_o,
  output logic      serial_in_o,
  input  wire logic serial_out_i,
  input  wire logic serial_out_oe_i
);
  initial begin
    link_sclk_o = 1'b0;
    chip_select_low_o = 1'b1;
    serial_in_o = 1'b0;
  end
  // Data line toggles while deselected so no stale level can be trusted
  always #12 if (chip_select_low_o) serial_in_o = ~serial_in_o;

  task automatic xfer(input logic [23:0] wr, output logic [23:0] rd);
    #3 chip_select_low_o = 1'b0;
    #400;
    for (int i = 23; i >= 0; i--) begin
      serial_in_o = wr[i];
      #6 rd[i] = serial_out_oe_i ? serial_out_i : 1'bx;
      link_sclk_o = 1'b1;
      #6 link_sclk_o = 1'b0;
    end
    rd[23] = 1'b0;
    #6 chip_select_low_o = 1'b1;
    #400;
  endtask
endmodule

// File: testbench/half_bridge_output_control_bench.sv
// Purpose: Self-checking bench for the half-bridge control block
// Assumes: Link master model supplies whole 24-bit frames
// Notes:   Expected values queue up; a watcher compares them in order
`timescale 1ns/1ns
module half_bridge_output_control_bench;
  import half_bridge_pkg::*;
  logic        clk_i, reset_n_i, link_sclk_i, chip_select_low_i;
  logic        serial_in_i, serial_out_o, serial_out_oe_o;
  logic        device_enable_i, oc_clear_i, other_flags_i, test_mode_i;
  logic        pwm_gate_input_a_i, pwm_gate_input_b_i;
  logic [4:0]  pwm_enable_i, pwm_select_b_i, upper_switch_o, lower_switch_o;
  logic [4:0]  gv;
  logic [9:0]  recovery_enable_i, oc_sense_i, oc_flags_o, cmd;
  analog_mux_t analog_mux_select_o;
  logic [23:0] rd_word;
  logic [31:0] r;
  logic [32:0] notes [$];
  logic [5:0]  pat [7] = '{6'h00, 6'h03, 6'h0c, 6'h0f, 6'h30, 6'h3f, 6'h21};
  int          n_errors = 0;
  int          comparisons = 0;

  half_bridge_output_control half_bridge_output_control_inst (
    .clk_i, .reset_n_i, .link_sclk_i, .chip_select_low_i, .serial_in_i,
    .serial_out_o, .serial_out_oe_o, .device_enable_i, .oc_clear_i,
    .pwm_enable_i, .pwm_select_b_i, .recovery_enable_i, .other_flags_i,
    .pwm_gate_input_a_i, .pwm_gate_input_b_i, .test_mode_i, .oc_sense_i,
    .upper_switch_o, .lower_switch_o, .oc_flags_o, .analog_mux_select_o);
  link_master_model link_master_model_inst (
    .link_sclk_o(link_sclk_i), .chip_select_low_o(chip_select_low_i),
    .serial_in_o(serial_in_i), .serial_out_i(serial_out_o),
    .serial_out_oe_i(serial_out_oe_o));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic note(input logic [32:0] e);
    notes.push_back(e);
  endtask
  function automatic logic [32:0] sv(analog_mux_t m, logic [9:0] f, s);
    return {10'h000, m, f, s};
  endfunction
  // Expected {upper, lower}; a bridge with both bits set stays off
  function automatic logic [9:0] drive(logic [9:0] c, logic [4:0] g);
    for (int k = 0; k < 5; k++) begin
      drive[k+5] = c[2*k+1] & ~c[2*k] & g[k];
      drive[k] = c[2*k] & ~c[2*k+1] & g[k];
    end
  endfunction
  task automatic frame(input logic [23:0] w);
    link_master_model_inst.xfer(w, rd_word);
    tick(6);
  endtask
  task automatic trip(input logic [9:0] v);
    oc_sense_i <= v;
    tick(3);
    oc_sense_i <= 10'h000;
    tick(6);
  endtask
  task automatic clear();
    oc_clear_i <= 1'b1;
    tick(1);
    oc_clear_i <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk_i) begin : watch
    logic [32:0] e;
    logic [32:0] got;
    #1;
    while (notes.size() > 0) begin
      e = notes.pop_front();
      got = e[32] ? {9'h100, rd_word} : sv(analog_mux_select_o, oc_flags_o,
                                           {upper_switch_o, lower_switch_o});
      comparisons++;
      if (got !== e) begin
        n_errors++;
        $display("wrong value at %0t: got %h expected %h", $time, got, e);
      end
    end
  end

  initial begin
    tick(9000);
    n_errors++;
    end_of_test();
  end

  initial begin
    {reset_n_i, oc_clear_i, other_flags_i, test_mode_i} = 4'h0;
    {device_enable_i, pwm_gate_input_a_i, pwm_gate_input_b_i} = 3'h4;
    {pwm_enable_i, pwm_select_b_i} = 10'h000;
    {recovery_enable_i, oc_sense_i} = 20'h00000;
    r = $urandom(18);
    tick(10);
    reset_n_i <= 1'b1;
    tick(3);
    note(sv(MUX_NONE, 10'h000, 10'h000));
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      cmd = (i == 0) ? 10'h3ff : r[9:0];
      frame({r[22:10], cmd, r[23]});
      note({9'h100, 24'h000001});
      note(sv(MUX_NONE, 10'h000, drive(cmd, 5'h1f)));
    end
    $display("test random commands done");
    pwm_enable_i <= 5'h1f;
    pwm_select_b_i <= 5'h05;
    frame(24'h000554);
    for (int g = 0; g < 4; g++) begin
      {pwm_gate_input_a_i, pwm_gate_input_b_i} <= g[1:0];
      gv = ({5{g[1]}} & 5'h1a) | ({5{g[0]}} & 5'h05);
      tick(6);
      note(sv(MUX_NONE, 10'h000, drive(10'h2aa, gv)));
    end
    pwm_enable_i <= 5'h00;
    $display("test pwm gating done");
    frame(24'h000002);
    trip(10'h001);
    note(sv(MUX_NONE, 10'h001, 10'h000));
    frame(24'h000002);
    note({9'h100, 24'h000002});
    tick(900);
    note(sv(MUX_NONE, 10'h001, 10'h000));
    clear();
    tick(6);
    note(sv(MUX_NONE, 10'h000, 10'h001));
    other_flags_i <= 1'b1;
    frame(24'h000002);
    note({9'h100, 24'h000000});
    other_flags_i <= 1'b0;
    $display("test latched trip done");
    recovery_enable_i <= 10'h001;
    for (int d = 0; d < 2; d++) begin
      frame({2'h0, d[0], 21'h000002});
      trip(10'h001);
      tick(d ? 381 : 781);
      note(sv(MUX_NONE, 10'h001, 10'h000));
      tick(30);
      note(sv(MUX_NONE, 10'h001, 10'h001));
      clear();
      tick(2);
    end
    recovery_enable_i <= 10'h000;
    $display("test recovery done");
    test_mode_i <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      frame({13'h0000, pat[k], 5'h00});
      note(sv(analog_mux_t'(k), 10'h000, 10'h000));
    end
    test_mode_i <= 1'b0;
    $display("test mode select done");
    frame(24'h0002aa);
    trip(10'h004);
    note(sv(MUX_NONE, 10'h004, 10'h01d));
    device_enable_i <= 1'b0;
    frame(24'h0002aa);
    note(sv(MUX_NONE, 10'h000, 10'h000));
    device_enable_i <= 1'b1;
    tick(6);
    note(sv(MUX_NONE, 10'h000, 10'h000));
    frame(24'h0002aa);
    reset_n_i <= 1'b0;
    tick(4);
    reset_n_i <= 1'b1;
    tick(3);
    note(sv(MUX_NONE, 10'h000, 10'h000));
    $display("test standby done");
    tick(2);
    end_of_test();
  end
endmodule
